// ===== include/cvp_pkg.sv
// constants and register map of the converter control block
`default_nettype none
package cvp_pkg;
    localparam int MCLK_MHZ       = 10;
    localparam logic [7:0] REG_OUTPUT_VOLTAGE_SELECT   = 8'h00;
    localparam logic [7:0] REG_SYSCTL = 8'h01;
    localparam logic [7:0] REG_ID     = 8'h02;
    localparam logic [7:0] REG_STAT   = 8'h03;
    localparam logic [7:0] OUTPUT_VOLTAGE_SELECT_RST   = 8'h80;
    localparam logic [7:0] SYSCTL_RST = 8'hA1;
    localparam int OUTPUT_VOLTAGE_SELECT_LOOP_BIT  = 7;
    localparam int SYS_EN_BIT     = 7;
    localparam int SYS_GO_BIT     = 6;
    localparam int SYS_SLEW_LSB   = 3;
    localparam int SYS_FS_LSB     = 1;
    localparam int SYS_MODE_BIT   = 0;
    localparam logic [6:0] ADDR_DEFAULT = 7'h62;
    localparam logic [6:0] ADDR_STRAP   = 7'h6A;
    // identification values are arbitrary
    localparam logic [3:0] VENDOR_CODE  = 4'h5;
    localparam logic [3:0] REVISION     = 4'h1;
    localparam int PCT_UNIT       = 100;
    localparam int OVP_ENTER_PCT  = 120;
    localparam int OVP_EXIT_PCT   = 105;
    localparam int UV_PCT         = 70;
    localparam int OK_LO_PCT      = 90;
    localparam int OK_HI_PCT      = 110;
    localparam int REF_BASE_MV    = 600;
    localparam int REF_STEP_MV    = 10;
    localparam int GO_KEEP_MV     = 50;
    localparam int GO_KEEP_CODES  = GO_KEEP_MV / REF_STEP_MV;
    localparam int REF_SETTLE_US  = 10;
    localparam int REF_SETTLE_CYC = REF_SETTLE_US * MCLK_MHZ;
    localparam int SEQ_STEP_US    = 2;
    localparam int SEQ_STEP_CYC   = SEQ_STEP_US * MCLK_MHZ;
    localparam int HICCUP_OFF_US  = 300;
    localparam int HICCUP_OFF_CYC = HICCUP_OFF_US * MCLK_MHZ;
    // fastest slew in units of 0.5 mV/us
    localparam int SLEW_MAX_HALF  = 128;
    // cycles per reference code step, rounded up
    function automatic logic [7:0] slew_cycles(input logic [2:0] sel);
        int r;
        r = SLEW_MAX_HALF >> sel;
        return 8'((2 * REF_STEP_MV * MCLK_MHZ + r - 1) / r);
    endfunction
endpackage
`default_nettype wire

// ===== rtl/cvp_ctrl.sv
// converter control, protection sequencing and i2c register slave
`default_nettype none
// Notes on behaviour
// R1 - over-voltage watch uses feedback pin when loop bit is 1, output sense otherwise
// R2 - linear discharge above 120% of reference, left below 105%
// R3 - peak limit turns high side off, low side on until valley clears
// R4 - overcurrent with voltage 30% under reference enters hiccup, restarts periodically
// R5 - over-temperature indication shuts converter down until it clears
// R6 - start-up enables reference block first, then internal regulator
// R7 - shutdown blocks signal path first, then pulls down error amp and rail
// R8 - after enable the feedback divider loop regulates without any i2c command
// R9 - loop bit 0 selects i2c reference and disables feedback loop
// R10 - reference starts at 0.6V after enabling
// R11 - valid reference byte ramps reference at slew chosen by 3-bit field
// R12 - slave address 1100010, or 1101010 when strap pin is grounded
// R13 - sda changes only while scl is low
// R14 - master makes start and stop; repeated start acts as start
// R15 - master keeps bus busy until 4.7us after stop
// R16 - each byte is eight bits plus acknowledge held low by receiver
// R17 - address byte carries seven address bits and direction bit
// R18 - update is address, register byte and data byte, each acknowledged
// R19 - register written on scl fall ending data byte lsb
// R20 - reference writes need arm bit; it self clears unless change within 50mV
// R21 - reference code maps 0.6V to 1.87V in equal 10mV steps
// R22 - scaling done reads 1 while output within 90-110% of reference
// R23 - overcurrent status reads high during hiccup
// R24 - read returns most recently addressed register after repeated start
// R25 - writes to read-only or unlisted addresses change nothing
module cvp_ctrl (
    input  wire logic        mclk,
    input  wire logic        lclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        en_pin,
    input  wire logic        vin_ok,
    input  wire logic        over_temp,
    input  wire logic        thermal_early_warning,
    input  wire logic        peak_ilim,
    input  wire logic        valley_ilim,
    input  wire logic        power_good,
    input  wire logic        pwm_on,
    input  wire logic [10:0] fb_mv,
    input  wire logic [10:0] vout_mv,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        address_strap_pin,
    output logic             sda_out,
    output logic             sda_drive_n,
    output logic             high_side_switch,
    output logic             low_side_switch,
    output logic             linear_discharge,
    output logic             ref_block_en,
    output logic             ldo_en,
    output logic             signal_path_en,
    output logic             comp_pulldown,
    output logic             rail_pulldown,
    output logic             fb_loop_en,
    output logic [6:0]       ref_code,
    output logic [1:0]       sw_freq_sel,
    output logic             ccm_force,
    output logic             overcurrent_flag,
    output logic             scaling_done
);
    import cvp_pkg::*;

    typedef enum logic [6:0] {
        ST_OFF = 7'h01, ST_REF = 7'h02, ST_LDO = 7'h04, ST_RUN = 7'h08,
        ST_HICCUP = 7'h10, ST_BLOCK = 7'h20, ST_PULL = 7'h40
    } cvp_pstate_t;

    typedef enum logic [7:0] {
        IS_IDLE = 8'h01, IS_ADDR = 8'h02, IS_AACK = 8'h04, IS_REG = 8'h08,
        IS_WDATA = 8'h10, IS_WACK = 8'h20, IS_RDATA = 8'h40, IS_RACK = 8'h80
    } cvp_istate_t;

    typedef struct packed {
        logic [6:0]  pin_s1;
        logic [6:0]  pin_s2;
        logic [15:0] cfg_s1;
        logic [15:0] cfg_s2;
        logic        wr_s1;
        logic        wr_s2;
        logic        wr_s3;
        cvp_pstate_t state;
        logic [11:0] timer;
        logic [6:0]  ref_now;
        logic [6:0]  ref_tgt;
        logic [7:0]  slew_cnt;
        logic        go_pend;
        logic        go_tog;
        logic        ilim_hold;
        logic        discharge;
        logic        hs;
        logic        ls;
        logic        ref_en;
        logic        ldo_en;
        logic        path_en;
        logic        comp_pd;
        logic        rail_pd;
        logic        oc;
        logic        done;
        logic [4:0]  stat;
    } cvp_cv_st_t;

    typedef struct packed {
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_d;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_d;
        logic        strap_s1;
        logic        strap_s2;
        logic [4:0]  st_s1;
        logic [4:0]  st_s2;
        logic        gc_s1;
        logic        gc_s2;
        logic        gc_s3;
        cvp_istate_t state;
        logic [3:0]  cnt;
        logic [7:0]  shreg;
        logic [7:0]  ptr;
        logic        rw;
        logic        nack;
        logic        drive_n;
        logic        sda_low;
        logic [7:0]  output_voltage_select;
        logic [7:0]  sysctl;
        logic        wr_tog;
    } cvp_i2_st_t;

    cvp_cv_st_t s, next_s;
    cvp_i2_st_t l, next_l;

    // converter domain
    logic [6:0]  pe;
    logic        en_ok, wr_ev, ovp_hi, ovp_lo, uv, in_ok;
    logic [10:0] mon_mv, ref_mv;
    logic [19:0] mon_x, ref_x;

    always_comb begin
        next_s = s;
        pe = s.pin_s2;
        next_s.pin_s1 = {power_good, valley_ilim, peak_ilim, thermal_early_warning,
                         over_temp, vin_ok, en_pin};
        next_s.pin_s2 = s.pin_s1;
        next_s.cfg_s1 = {l.output_voltage_select, l.sysctl};
        next_s.cfg_s2 = s.cfg_s1;
        next_s.wr_s1 = l.wr_tog;
        next_s.wr_s2 = s.wr_s1;
        next_s.wr_s3 = s.wr_s2;
        wr_ev = s.wr_s2 ^ s.wr_s3;
        en_ok = pe[0] & pe[1] & s.cfg_s2[SYS_EN_BIT] & ~pe[2]; // R5 R6 R7
        mon_mv = s.cfg_s2[8 + OUTPUT_VOLTAGE_SELECT_LOOP_BIT] ? fb_mv : vout_mv; // R1
        ref_mv = 11'(REF_BASE_MV) + 11'(s.ref_now) * 11'(REF_STEP_MV); // R21
        mon_x = 20'(mon_mv) * 20'(PCT_UNIT);
        ref_x = 20'(ref_mv);
        ovp_hi = mon_x > ref_x * 20'(OVP_ENTER_PCT); // R2
        ovp_lo = mon_x < ref_x * 20'(OVP_EXIT_PCT); // R2
        uv = mon_x < ref_x * 20'(UV_PCT); // R4
        in_ok = mon_x >= ref_x * 20'(OK_LO_PCT) && mon_x <= ref_x * 20'(OK_HI_PCT); // R22
        if (s.timer != 12'h000) begin
            next_s.timer = s.timer - 12'h001;
        end
        if (pe[4]) begin
            next_s.ilim_hold = 1'b1; // R3
        end else if (!pe[5]) begin
            next_s.ilim_hold = 1'b0; // R3
        end
        unique case (s.state)
            ST_OFF: begin
                next_s.comp_pd = 1'b1;
                next_s.rail_pd = 1'b1;
                if (en_ok) begin
                    next_s.state = ST_REF; // R6
                    next_s.ref_en = 1'b1;
                    next_s.timer = 12'(REF_SETTLE_CYC - 1);
                end
            end
            ST_REF: begin
                if (!en_ok) begin
                    next_s.state = ST_BLOCK;
                    next_s.timer = 12'(SEQ_STEP_CYC - 1);
                end else if (s.timer == 12'h000) begin
                    next_s.state = ST_LDO; // R6
                    next_s.ldo_en = 1'b1;
                    next_s.comp_pd = 1'b0;
                    next_s.rail_pd = 1'b0;
                    next_s.timer = 12'(SEQ_STEP_CYC - 1);
                end
            end
            ST_LDO: begin
                if (!en_ok) begin
                    next_s.state = ST_BLOCK;
                    next_s.timer = 12'(SEQ_STEP_CYC - 1);
                end else if (s.timer == 12'h000) begin
                    next_s.state = ST_RUN; // R8
                    next_s.path_en = 1'b1;
                end
            end
            ST_RUN: begin
                if (!en_ok) begin
                    next_s.state = ST_BLOCK; // R7
                    next_s.path_en = 1'b0;
                    next_s.timer = 12'(SEQ_STEP_CYC - 1);
                end else if (s.ilim_hold && uv) begin
                    next_s.state = ST_HICCUP; // R4
                    next_s.timer = 12'(HICCUP_OFF_CYC - 1);
                end
            end
            ST_HICCUP: begin
                next_s.ilim_hold = 1'b0;
                if (!en_ok) begin
                    next_s.state = ST_BLOCK;
                    next_s.path_en = 1'b0;
                    next_s.timer = 12'(SEQ_STEP_CYC - 1);
                end else if (s.timer == 12'h000) begin
                    next_s.state = ST_RUN; // R4
                end
            end
            ST_BLOCK: begin
                next_s.path_en = 1'b0;
                if (s.timer == 12'h000) begin
                    next_s.state = ST_PULL; // R7
                    next_s.comp_pd = 1'b1;
                    next_s.rail_pd = 1'b1;
                    next_s.timer = 12'(SEQ_STEP_CYC - 1);
                end
            end
            ST_PULL: begin
                if (s.timer == 12'h000) begin
                    next_s.state = ST_OFF;
                    next_s.ref_en = 1'b0;
                    next_s.ldo_en = 1'b0;
                end
            end
        endcase
        if (next_s.state == ST_OFF) begin
            next_s.ref_now = 7'h00; // R10
            next_s.ref_tgt = 7'h00;
            next_s.go_pend = 1'b0;
            next_s.discharge = 1'b0;
        end else begin
            if (ovp_hi) begin
                next_s.discharge = 1'b1; // R2
            end else if (ovp_lo) begin
                next_s.discharge = 1'b0;
            end
            if (wr_ev) begin
                next_s.ref_tgt = s.cfg_s2[14:8]; // R11
                next_s.go_pend = (s.cfg_s2[14:8] > s.ref_now + 7'(GO_KEEP_CODES))
                              || (s.ref_now > s.cfg_s2[14:8] + 7'(GO_KEEP_CODES)); // R20
                next_s.slew_cnt = 8'h00;
            end else if (s.ref_now != s.ref_tgt) begin
                if (s.slew_cnt == 8'h00) begin
                    next_s.ref_now = (s.ref_tgt > s.ref_now) ? s.ref_now + 7'h01
                                                             : s.ref_now - 7'h01; // R11
                    next_s.slew_cnt = slew_cycles(s.cfg_s2[SYS_SLEW_LSB +: 3]) - 8'h01;
                end else begin
                    next_s.slew_cnt = s.slew_cnt - 8'h01;
                end
            end else if (s.go_pend) begin
                next_s.go_pend = 1'b0; // R20
                next_s.go_tog = ~s.go_tog;
            end
        end
        next_s.hs = (next_s.state == ST_RUN) && pwm_on && !next_s.ilim_hold; // R3
        next_s.ls = (next_s.state == ST_RUN) && (next_s.ilim_hold || !pwm_on); // R3
        next_s.oc = next_s.state == ST_HICCUP; // R23
        next_s.done = in_ok; // R22
        next_s.stat = {next_s.done, next_s.oc, pe[3], pe[2], pe[6]};
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '{state: ST_OFF, cfg_s1: {OUTPUT_VOLTAGE_SELECT_RST, SYSCTL_RST},
                   cfg_s2: {OUTPUT_VOLTAGE_SELECT_RST, SYSCTL_RST}, comp_pd: 1'b1, rail_pd: 1'b1,
                   default: '0};
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // link domain
    logic       rise, fall, start, stop, go_clr;
    logic [6:0] my_addr;
    logic [7:0] rd_val;

    always_comb begin
        next_l = l;
        next_l.scl_s1 = scl_in;
        next_l.scl_s2 = l.scl_s1;
        next_l.scl_d = l.scl_s2;
        next_l.sda_s1 = sda_in;
        next_l.sda_s2 = l.sda_s1;
        next_l.sda_d = l.sda_s2;
        next_l.strap_s1 = address_strap_pin;
        next_l.strap_s2 = l.strap_s1;
        next_l.st_s1 = s.stat;
        next_l.st_s2 = l.st_s1;
        next_l.gc_s1 = s.go_tog;
        next_l.gc_s2 = l.gc_s1;
        next_l.gc_s3 = l.gc_s2;
        rise = l.scl_s2 & ~l.scl_d;
        fall = ~l.scl_s2 & l.scl_d;
        start = l.scl_s2 & l.scl_d & l.sda_d & ~l.sda_s2; // R14
        stop = l.scl_s2 & l.scl_d & ~l.sda_d & l.sda_s2;
        go_clr = l.gc_s2 ^ l.gc_s3;
        my_addr = l.strap_s2 ? ADDR_DEFAULT : ADDR_STRAP; // R12
        unique case (l.ptr)
            REG_OUTPUT_VOLTAGE_SELECT:   rd_val = l.output_voltage_select;
            REG_SYSCTL: rd_val = l.sysctl;
            REG_ID:     rd_val = {VENDOR_CODE, REVISION};
            REG_STAT:   rd_val = {3'h0, l.st_s2};
            default:    rd_val = 8'h00;
        endcase
        if (go_clr) begin
            next_l.sysctl[SYS_GO_BIT] = 1'b0; // R20
        end
        if ((l.state & (IS_ADDR | IS_REG | IS_WDATA)) != 8'h00 && rise && l.cnt < 4'h8) begin
            next_l.shreg = {l.shreg[6:0], l.sda_s2}; // R16
            next_l.cnt = l.cnt + 4'h1;
        end
        unique case (l.state)
            IS_IDLE: begin
            end
            IS_ADDR: begin
                if (fall && l.cnt == 4'h8) begin
                    if (l.shreg[7:1] == my_addr) begin
                        next_l.drive_n = 1'b0; // R16
                        next_l.rw = l.shreg[0]; // R17
                        next_l.state = IS_AACK;
                    end else begin
                        next_l.state = IS_IDLE;
                    end
                end
            end
            IS_AACK: begin
                if (fall) begin
                    next_l.cnt = 4'h0;
                    if (l.rw) begin
                        next_l.shreg = rd_val; // R24
                        next_l.drive_n = rd_val[7];
                        next_l.state = IS_RDATA;
                    end else begin
                        next_l.drive_n = 1'b1;
                        next_l.state = IS_REG;
                    end
                end
            end
            IS_REG: begin
                if (fall && l.cnt == 4'h8) begin
                    next_l.ptr = l.shreg; // R18
                    next_l.drive_n = 1'b0;
                    next_l.state = IS_WACK;
                end
            end
            IS_WDATA: begin
                if (fall && l.cnt == 4'h8) begin
                    next_l.drive_n = 1'b0; // R18
                    next_l.state = IS_WACK;
                    if (l.ptr == REG_OUTPUT_VOLTAGE_SELECT) begin
                        next_l.output_voltage_select[OUTPUT_VOLTAGE_SELECT_LOOP_BIT] = l.shreg[OUTPUT_VOLTAGE_SELECT_LOOP_BIT]; // R19 R9
                        if (l.sysctl[SYS_GO_BIT]) begin
                            next_l.output_voltage_select[6:0] = l.shreg[6:0]; // R20
                            next_l.wr_tog = ~l.wr_tog;
                        end
                    end else if (l.ptr == REG_SYSCTL) begin
                        next_l.sysctl = l.shreg; // R19
                    end // R25
                end
            end
            IS_WACK: begin
                if (fall) begin
                    next_l.drive_n = 1'b1;
                    next_l.cnt = 4'h0;
                    next_l.state = IS_WDATA;
                end
            end
            IS_RDATA: begin
                if (rise) begin
                    next_l.cnt = l.cnt + 4'h1;
                end else if (fall) begin
                    if (l.cnt == 4'h8) begin
                        next_l.drive_n = 1'b1; // R16
                        next_l.state = IS_RACK;
                    end else begin
                        next_l.shreg = {l.shreg[6:0], 1'b0};
                        next_l.drive_n = l.shreg[6]; // R13
                    end
                end
            end
            IS_RACK: begin
                if (rise) begin
                    next_l.nack = l.sda_s2;
                end else if (fall) begin
                    next_l.cnt = 4'h0;
                    next_l.shreg = rd_val;
                    next_l.drive_n = l.nack | rd_val[7];
                    next_l.state = l.nack ? IS_IDLE : IS_RDATA;
                end
            end
        endcase
        if (start) begin
            next_l.state = IS_ADDR; // R14
            next_l.cnt = 4'h0;
            next_l.drive_n = 1'b1;
        end else if (stop) begin
            next_l.state = IS_IDLE;
            next_l.drive_n = 1'b1;
        end
    end

    always_ff @(posedge lclk or posedge sys_rst) begin
        if (sys_rst) begin
            l <= '{state: IS_IDLE, drive_n: 1'b1, scl_s1: 1'b1, scl_s2: 1'b1,
                   scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                   output_voltage_select: OUTPUT_VOLTAGE_SELECT_RST, sysctl: SYSCTL_RST, default: '0};
        end else if (clk_en) begin
            l <= next_l;
        end
    end

    assign sda_out = l.sda_low;
    assign sda_drive_n = l.drive_n;
    assign high_side_switch = s.hs;
    assign low_side_switch = s.ls;
    assign linear_discharge = s.discharge;
    assign ref_block_en = s.ref_en;
    assign ldo_en = s.ldo_en;
    assign signal_path_en = s.path_en;
    assign comp_pulldown = s.comp_pd;
    assign rail_pulldown = s.rail_pd;
    assign fb_loop_en = s.cfg_s2[8 + OUTPUT_VOLTAGE_SELECT_LOOP_BIT];
    assign ref_code = s.ref_now;
    assign sw_freq_sel = s.cfg_s2[SYS_FS_LSB +: 2];
    assign ccm_force = s.cfg_s2[SYS_MODE_BIT];
    assign overcurrent_flag = s.oc;
    assign scaling_done = s.done;

    a_ovp_enter: assert property (@(posedge mclk) disable iff (sys_rst) // R2
        clk_en && ovp_hi && s.state != ST_OFF && next_s.state != ST_OFF |=> s.discharge)
        else $error("discharge not entered above limit");
    a_ovp_exit: assert property (@(posedge mclk) disable iff (sys_rst) // R2
        clk_en && ovp_lo && !ovp_hi |=> !s.discharge)
        else $error("discharge held below exit level");
    a_ilim_hs_off: assert property (@(posedge mclk) disable iff (sys_rst) // R3
        s.ilim_hold |-> !s.hs && (s.ls || s.state != ST_RUN))
        else $error("high side on during current limit");
    a_hiccup_enter: assert property (@(posedge mclk) disable iff (sys_rst) // R4
        clk_en && s.state == ST_RUN && en_ok && s.ilim_hold && uv
        |=> s.state == ST_HICCUP && overcurrent_flag)
        else $error("hiccup not entered");
    a_thermal_off: assert property (@(posedge mclk) disable iff (sys_rst) // R5
        clk_en && s.pin_s2[2] && s.state == ST_RUN |=> s.state == ST_BLOCK && !s.path_en)
        else $error("no shutdown on over temperature");
    a_start_order: assert property (@(posedge mclk) disable iff (sys_rst) // R6
        $rose(s.ldo_en) |-> $past(s.ref_en) && $past(s.state) == ST_REF)
        else $error("regulator before reference");
    a_stop_order: assert property (@(posedge mclk) disable iff (sys_rst) // R7
        $rose(s.comp_pd) |-> !s.path_en && !$past(s.path_en))
        else $error("pulldown before path blocked");
    a_ref_default: assert property (@(posedge mclk) disable iff (sys_rst) // R10
        $rose(s.ref_en) |-> s.ref_now == 7'h00 && ref_code == 7'h00)
        else $error("reference not at default after enable");
    a_slew_step: assert property (@(posedge mclk) disable iff (sys_rst) // R11
        $changed(s.ref_now) && s.state != ST_OFF
        |-> s.ref_now == $past(s.ref_now) + 7'h01 || s.ref_now == $past(s.ref_now) - 7'h01)
        else $error("reference jumped");
    a_sda_drive: assert property (@(posedge lclk) disable iff (sys_rst) // R13
        $fell(l.drive_n) |-> !l.scl_s2)
        else $error("sda pulled while scl high");
    a_wr_gate: assert property (@(posedge lclk) disable iff (sys_rst) // R20
        $changed(l.output_voltage_select[6:0]) |-> $past(l.sysctl[SYS_GO_BIT]) && $past(l.ptr) == REG_OUTPUT_VOLTAGE_SELECT)
        else $error("reference written without arm");
    c_hiccup: cover property (@(posedge mclk) disable iff (sys_rst) $rose(s.oc));
    c_discharge: cover property (@(posedge mclk) disable iff (sys_rst) $rose(s.discharge));
    c_read: cover property (@(posedge lclk) disable iff (sys_rst) l.state == IS_RACK);
    c_go_clear: cover property (@(posedge lclk) disable iff (sys_rst) go_clr);
endmodule // cvp_ctrl
`default_nettype wire

// ===== dv/cvp_i2c_master.sv
// i2c bus master model on open-drain lines with pull-up
`default_nettype none
module cvp_i2c_master (
    input  wire logic sda_drive_n,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns / 1ns;
    logic sdo = 1'b1;
    initial scl = 1'b1;
    assign sda = sdo & sda_drive_n;
    task automatic clk(input logic b, output logic r);
        #150 sdo = b;
        #150 scl = 1'b1;
        #300 r = sda;
        scl = 1'b0;
    endtask
    task automatic st();
        #150 sdo = 1'b1;
        #150 scl = 1'b1;
        #300 sdo = 1'b0;
        #300 scl = 1'b0;
    endtask
    task automatic sp();
        #150 sdo = 1'b0;
        #150 scl = 1'b1;
        #300 sdo = 1'b1;
        #4800;
    endtask
    task automatic xb(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) clk(d[i], q[i]);
        clk(m, a);
    endtask
endmodule // cvp_i2c_master
`default_nettype wire

// ===== dv/cvp_ctrl_test.sv
// self-checking bench for the converter control block
`default_nettype none
module cvp_ctrl_test import cvp_pkg::*;;
    timeunit 1ns / 1ns;
    logic mclk = 0, lclk = 0, sys_rst = 1, en_pin = 0, vin_ok = 0, peak_ilim = 0, pwm = 1;
    logic scl, sda, sdn, hs, ls, ld, rbe, ldo, spe, cpd, fle;
    logic ot = 0, strap = 1;
    logic [10:0] vout_mv = 11'h000;
    logic [6:0] ref_code;
    logic [7:0] q;
    int mismatches = 0, tests_run = 0;
    initial forever #50 mclk = ~mclk;
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end
    cvp_ctrl dut (.mclk(mclk), .lclk(lclk), .sys_rst(sys_rst), .clk_en(1'b1), .en_pin(en_pin),
        .vin_ok(vin_ok), .over_temp(ot), .thermal_early_warning(1'b0), .peak_ilim(peak_ilim),
        .valley_ilim(1'b0), .power_good(1'b0), .pwm_on(pwm), .fb_mv(11'h000),
        .vout_mv(vout_mv), .scl_in(scl), .sda_in(sda), .address_strap_pin(strap), .sda_out(),
        .sda_drive_n(sdn), .high_side_switch(hs), .low_side_switch(ls), .linear_discharge(ld),
        .ref_block_en(rbe), .ldo_en(ldo), .signal_path_en(spe), .comp_pulldown(cpd),
        .rail_pulldown(), .fb_loop_en(fle), .ref_code(ref_code), .sw_freq_sel(),
        .ccm_force(), .overcurrent_flag(), .scaling_done());
    cvp_i2c_master m (.sda_drive_n(sdn), .scl(scl), .sda(sda));
    task automatic cy(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] r, d, input logic [6:0] ad = ADDR_DEFAULT,
                      input logic [7:0] e = 8'h00);
        logic [7:0] x;
        logic a, b, c;
        m.st();
        m.xb({ad, 1'b0}, 1'b1, x, a);
        m.xb(r, 1'b1, x, b);
        m.xb(d, 1'b1, x, c);
        m.sp();
        chk("wack", {5'h00, a, b, c}, e);
    endtask
    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        logic a, b, c;
        m.st();
        m.xb({ADDR_DEFAULT, 1'b0}, 1'b1, d, a);
        m.xb(r, 1'b1, d, b);
        m.st();
        m.xb({ADDR_DEFAULT, 1'b1}, 1'b1, d, c);
        chk("rack", {5'h00, a, b, c}, 8'h00);
        m.xb(8'hFF, 1'b1, d, a);
        m.sp();
    endtask
    task automatic ov(input logic [10:0] v, input logic e);
        vout_mv = v;
        cy(5);
        chk("dis", {7'h00, ld}, {7'h00, e});
    endtask
    initial begin
        #3000000;
        mismatches++;
        close_out();
    end
    initial begin
        cy(6);
        sys_rst = 0;
        chk("pull", {6'h00, cpd, fle}, 8'h03);
        en_pin = 1;
        vin_ok = 1;
        cy(50);
        chk("seq1", {6'h00, rbe, ldo}, 8'h02);
        cy(100);
        chk("seq2", {6'h00, ldo, cpd}, 8'h02);
        cy(50);
        chk("run", {spe, ref_code}, 8'h80);
        rd(REG_ID, q);
        chk("id", q, {VENDOR_CODE, REVISION});
        wr(REG_ID, 8'h00);
        rd(REG_ID, q);
        chk("ro", q, {VENDOR_CODE, REVISION});
        wr(REG_ID, 8'h00, ADDR_STRAP, 8'h07);
        strap = 0;
        cy(2);
        wr(REG_ID, 8'h00, ADDR_STRAP, 8'h00);
        wr(REG_ID, 8'h00, ADDR_DEFAULT, 8'h07);
        strap = 1;
        cy(2);
        wr(REG_SYSCTL, 8'hE1);
        wr(8'h00, 8'h05);
        cy(300);
        chk("code", {fle, ref_code}, 8'h05);
        rd(REG_SYSCTL, q);
        chk("arm", q, 8'hE1);
        wr(8'h00, 8'h14);
        cy(600);
        rd(REG_SYSCTL, q);
        chk("clr", q, 8'hA1);
        wr(8'h00, 8'h30);
        rd(8'h00, q);
        chk("keep", q, 8'h14);
        ov(11'd961, 1'b1);
        ov(11'd841, 1'b1);
        ov(11'd839, 1'b0);
        peak_ilim = 1;
        cy(5);
        chk("lim", {6'h00, hs, ls}, 8'h01);
        peak_ilim = 0;
        en_pin = 0;
        cy(10);
        chk("blk", {6'h00, spe, cpd}, 8'h00);
        cy(25);
        chk("pd", {7'h00, cpd}, 8'h01);
        ot = 1;
        en_pin = 1;
        cy(200);
        chk("hot", {7'h00, rbe}, 8'h00);
        ot = 0;
        cy(50);
        chk("cool", {7'h00, rbe}, 8'h01);
        close_out();
    end
endmodule // cvp_ctrl_test
`default_nettype wire
